// file: design/scmp_pkg.sv
package scmp_pkg;
  // ==========================================================
  // register byte offsets on the apb
  localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_AREA_WIDTH     = 8'h04;
  localparam logic [7:0] OFS_BUS_RELEASE    = 8'h08;
  localparam logic [7:0] OFS_PORT1_DIR      = 8'h0c;
  localparam logic [7:0] OFS_PORT2_DIR      = 8'h10;
  localparam logic [7:0] OFS_PORT5_DIR      = 8'h14;
  localparam logic [7:0] OFS_STATUS         = 8'h18;
  // ==========================================================
  // system control fields and reset values
  localparam int unsigned BIT_STANDBY_SEL   = 7;
  localparam int unsigned BIT_WAIT_HI       = 6;
  localparam int unsigned BIT_WAIT_LO       = 4;
  localparam int unsigned BIT_USER_FLAG_EN  = 3;
  localparam int unsigned BIT_NMI_EDGE      = 2;
  localparam int unsigned BIT_FIXED_ONE     = 1;
  localparam int unsigned BIT_RAM_EN        = 0;
  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h0b;
  localparam logic [7:0] RST_BUS_RELEASE    = 8'hff;
  localparam logic [7:0] RST_PORT_DIR       = 8'h00;
  localparam logic [7:0] AWC_ALL_8BIT       = 8'hff;
  localparam logic [7:0] AWC_ALL_16BIT      = 8'h00;
  // ==========================================================
  // settling waits in clock states, per wait select code
  localparam int unsigned WAIT_CODE0 = 8192;
  localparam int unsigned WAIT_CODE1 = 16384;
  localparam int unsigned WAIT_CODE2 = 32768;
  localparam int unsigned WAIT_CODE3 = 65536;
  localparam int unsigned WAIT_CODE4 = 131072;
  localparam int unsigned WAIT_CODE5 = 1024;
  localparam int unsigned WAIT_CNT_W = 17;
  // edges after reset release before the mode pins are latched
  localparam logic [1:0] STRAP_DELAY = 2'h2;
  // ==========================================================
  // power states and modes
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_STBY  = 2'b10,
    PWR_WAIT  = 2'b11
  } scmp_pwr_t;
  localparam logic [2:0] MODE_ILLEGAL = 3'h0;
  localparam logic [2:0] MODE_7       = 3'h7;
endpackage

// file: design/scmp_wait_if.sv
`timescale 1ns/1ns
interface scmp_wait_if;
  logic       start;
  logic [2:0] code;
  logic       done;
  modport ctl (output start, output code, input done);
  modport tmr (input start, input code, output done);
endinterface

// file: design/scmp_wait_timer.sv
`timescale 1ns/1ns
// oscillator settling counter for the exit from software standby
module scmp_wait_timer #(
  parameter int unsigned WAIT0 = scmp_pkg::WAIT_CODE0,
  parameter int unsigned WAIT1 = scmp_pkg::WAIT_CODE1,
  parameter int unsigned WAIT2 = scmp_pkg::WAIT_CODE2,
  parameter int unsigned WAIT3 = scmp_pkg::WAIT_CODE3,
  parameter int unsigned WAIT4 = scmp_pkg::WAIT_CODE4,
  parameter int unsigned WAIT5 = scmp_pkg::WAIT_CODE5
) (
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // start and done
  scmp_wait_if.tmr    wt
);
  localparam int unsigned W = scmp_pkg::WAIT_CNT_W;
  logic [W-1:0] count;
  logic         busy;
  logic [W-1:0] load;

  // ==========================================================
  // code to count; 11x is illegal, the longest wait is the safe one
  always_comb begin
    unique case (wt.code)
      3'h0:    load = W'(WAIT0 - 1);
      3'h1:    load = W'(WAIT1 - 1);
      3'h2:    load = W'(WAIT2 - 1);
      3'h3:    load = W'(WAIT3 - 1);
      3'h5:    load = W'(WAIT5 - 1);
      default: load = W'(WAIT4 - 1);
    endcase
  end

  // counts exactly the selected number of states, then pulses done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= '0;
      busy    <= 1'b0;
      wt.done <= 1'b0;
    end else begin
      wt.done <= 1'b0;
      if (wt.start) begin
        count <= load;
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy    <= 1'b0;
          wt.done <= 1'b1;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end
endmodule // scmp_wait_timer

// file: design/scmp_top.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
// Function
// - standby select picks sleep or software standby
// - wait select code sets settling states
// - wait applied only on interrupt exit
// - user flag enable chooses mask or user
// - nmi edge select picks falling or rising
// - bit 1 always reads one
// - ram enable set by reset, kept standby
// - ram enable bit gates on-chip ram
// - modes 1,2: ports 1,2,5 address A19-A0
// - modes 3,4: add port A, A23-A0
// - modes 1,3,5,6 start 8-bit bus
// - modes 2,4 start 16-bit bus
// - A20 always; A23-A21 need release bits zero
// - modes 5,6 address only where direction set
// - port 4 data in 16-bit; port 3 high data
// - mode 7 all ports general I/O
// - control resets to 0x0b, kept in software standby
// - standby select stays set after wake
// - mode pins pick 1-7, 000 illegal
module scmp_top #(
  parameter int unsigned WAIT0 = scmp_pkg::WAIT_CODE0,
  parameter int unsigned WAIT1 = scmp_pkg::WAIT_CODE1,
  parameter int unsigned WAIT2 = scmp_pkg::WAIT_CODE2,
  parameter int unsigned WAIT3 = scmp_pkg::WAIT_CODE3,
  parameter int unsigned WAIT4 = scmp_pkg::WAIT_CODE4,
  parameter int unsigned WAIT5 = scmp_pkg::WAIT_CODE5
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic [2:0]  mode_select_pins,
  input  wire logic        nmi_pin,
  input  wire logic        wake_irq_pin,
  input  wire logic        hw_standby_n_pin,
  // cpu side
  input  wire logic        halt_req,
  output logic             sleep_enter,
  output logic             soft_standby_enter,
  output logic             cpu_resume,
  output logic             secondary_mask_flag,
  output logic             nmi_request,
  output logic             onchip_ram_enable,
  // pin function selects
  output logic             bus_16bit,
  output logic             addr_space_16m,
  output logic [7:0]       port1_addr_en,
  output logic [7:0]       port2_addr_en,
  output logic [3:0]       port5_addr_en,
  output logic [7:4]       porta_addr_en,
  output logic             port3_data_en,
  output logic             port4_data_en
);
  // ==========================================================
  // registers and state
  logic [7:0]          system_control;
  logic [7:0]          area_width_control;
  logic [7:0]          bus_release_control;
  logic [7:0]          port1_direction;
  logic [7:0]          port2_direction;
  logic [7:0]          port5_direction;
  logic [2:0]          mode;
  logic                strap_done;
  logic [1:0]          strap_cnt;
  scmp_pkg::scmp_pwr_t pwr;
  logic [5:0]          sync1;
  logic [5:0]          sync2;
  logic                nmi_prev;
  logic                nmi_edge;
  logic                wr_en;
  logic                setup;
  logic                strap_now;
  logic                hw_stby;
  logic                wake;
  logic                expanded;
  logic                big_space;
  logic                rom_modes;
  logic                next_bus16;
  logic [7:0]          rd_mux;
  logic                rd_hit;
  scmp_wait_if         wt ();

  // ==========================================================
  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h30;
      sync2 <= 6'h30;
    end else begin
      sync1 <= {hw_standby_n_pin, nmi_pin, wake_irq_pin,
                mode_select_pins};
      sync2 <= sync1;
    end
  end

  assign hw_stby = !sync2[5];
  assign wake    = sync2[3];

  // ==========================================================
  // mode strap, caught once after reset release, never again
  assign strap_now = !strap_done && (strap_cnt == scmp_pkg::STRAP_DELAY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      mode       <= scmp_pkg::MODE_7;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_now) begin
        mode       <= sync2[2:0];
        strap_done <= 1'b1;
      end
    end
  end

  // ==========================================================
  // apb handshake: one wait-free access phase, answer registered
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      scmp_pkg::OFS_SYSTEM_CONTROL: rd_mux = system_control;
      scmp_pkg::OFS_AREA_WIDTH:     rd_mux = area_width_control;
      scmp_pkg::OFS_BUS_RELEASE:    rd_mux = bus_release_control;
      scmp_pkg::OFS_PORT1_DIR:      rd_mux = port1_direction;
      scmp_pkg::OFS_PORT2_DIR:      rd_mux = port2_direction;
      scmp_pkg::OFS_PORT5_DIR:      rd_mux = port5_direction;
      scmp_pkg::OFS_STATUS:
        rd_mux = {1'b0, pwr, mode == scmp_pkg::MODE_ILLEGAL,
                  bus_16bit, mode};
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // answer is built in the setup cycle, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !rd_hit;
      prdata  <= setup ? {24'h0, rd_mux} : 32'h0;
    end
  end

  // ==========================================================
  // system control register; hardware standby reinitialises all but the ram enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control <= scmp_pkg::RST_SYSTEM_CONTROL;
    end else if (hw_stby) begin
      // ram enable only follows the reset pin
      system_control[7:1] <= scmp_pkg::RST_SYSTEM_CONTROL[7:1];
    end else if (wr_en && paddr == scmp_pkg::OFS_SYSTEM_CONTROL) begin
      // bit 1 is not stored; it stays one
      system_control[7:2] <= pwdata[7:2];
      system_control[0]   <= pwdata[0];
      system_control[1]   <= 1'b1;
    end
  end

  // ==========================================================
  // bus controller and port direction registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area_width_control <= scmp_pkg::AWC_ALL_16BIT;
    end else if (strap_now) begin
      // initial bus width follows the latched mode
      if (sync2[2:0] == 3'h2 || sync2[2:0] == 3'h4)
        area_width_control <= scmp_pkg::AWC_ALL_16BIT;
      else
        area_width_control <= scmp_pkg::AWC_ALL_8BIT;
    end else if (wr_en && paddr == scmp_pkg::OFS_AREA_WIDTH) begin
      area_width_control <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_release_control <= scmp_pkg::RST_BUS_RELEASE;
      port1_direction     <= scmp_pkg::RST_PORT_DIR;
      port2_direction     <= scmp_pkg::RST_PORT_DIR;
      port5_direction     <= scmp_pkg::RST_PORT_DIR;
    end else if (wr_en) begin
      if (paddr == scmp_pkg::OFS_BUS_RELEASE)
        bus_release_control <= pwdata[7:0];
      if (paddr == scmp_pkg::OFS_PORT1_DIR)
        port1_direction <= pwdata[7:0];
      if (paddr == scmp_pkg::OFS_PORT2_DIR)
        port2_direction <= pwdata[7:0];
      if (paddr == scmp_pkg::OFS_PORT5_DIR)
        port5_direction <= {4'h0, pwdata[3:0]};
    end
  end

  // ==========================================================
  // power state machine for the halt instruction
  assign wt.code = system_control[scmp_pkg::BIT_WAIT_HI:
                                  scmp_pkg::BIT_WAIT_LO];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr                <= scmp_pkg::PWR_RUN;
      sleep_enter        <= 1'b0;
      soft_standby_enter <= 1'b0;
      cpu_resume         <= 1'b0;
      wt.start           <= 1'b0;
    end else begin
      sleep_enter        <= 1'b0;
      soft_standby_enter <= 1'b0;
      cpu_resume         <= 1'b0;
      wt.start           <= 1'b0;
      unique case (pwr)
        scmp_pkg::PWR_RUN: begin
          if (halt_req && !hw_stby) begin
            if (system_control[scmp_pkg::BIT_STANDBY_SEL]) begin
              pwr                <= scmp_pkg::PWR_STBY;
              soft_standby_enter <= 1'b1;
            end else begin
              pwr         <= scmp_pkg::PWR_SLEEP;
              sleep_enter <= 1'b1;
            end
          end
        end
        scmp_pkg::PWR_SLEEP: begin
          // sleep keeps the clock, so no settling wait
          if (wake || nmi_edge || hw_stby) begin
            pwr        <= scmp_pkg::PWR_RUN;
            cpu_resume <= 1'b1;
          end
        end
        scmp_pkg::PWR_STBY: begin
          // control bits are left alone, standby select stays one
          if (hw_stby) begin
            pwr <= scmp_pkg::PWR_RUN;
          end else if (wake || nmi_edge) begin
            pwr      <= scmp_pkg::PWR_WAIT;
            wt.start <= 1'b1;
          end
        end
        scmp_pkg::PWR_WAIT: begin
          if (wt.done) begin
            pwr        <= scmp_pkg::PWR_RUN;
            cpu_resume <= 1'b1;
          end else if (hw_stby) begin
            pwr <= scmp_pkg::PWR_RUN;
          end
        end
      endcase
    end
  end

  scmp_wait_timer #(
    .WAIT0 (WAIT0),
    .WAIT1 (WAIT1),
    .WAIT2 (WAIT2),
    .WAIT3 (WAIT3),
    .WAIT4 (WAIT4),
    .WAIT5 (WAIT5)
  ) u_wait (
    .pclk    (pclk),
    .presetn (presetn),
    .wt      (wt)
  );

  // ==========================================================
  // nmi edge detect on the synchronised pin
  assign nmi_edge = system_control[scmp_pkg::BIT_NMI_EDGE]
                    ? (sync2[4] && !nmi_prev)
                    : (!sync2[4] && nmi_prev);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev            <= 1'b1;
      nmi_request         <= 1'b0;
      secondary_mask_flag <= 1'b0;
      onchip_ram_enable   <= 1'b1;
    end else begin
      nmi_prev            <= sync2[4];
      nmi_request         <= nmi_edge;
      secondary_mask_flag <= !system_control[scmp_pkg::BIT_USER_FLAG_EN];
      onchip_ram_enable   <= system_control[scmp_pkg::BIT_RAM_EN];
    end
  end

  // ==========================================================
  // mode decode to pin functions
  assign expanded  = (mode != scmp_pkg::MODE_7) &&
                     (mode != scmp_pkg::MODE_ILLEGAL);
  assign big_space = (mode == 3'h3) || (mode == 3'h4) ||
                     (mode == 3'h6);
  assign rom_modes = (mode == 3'h5) || (mode == 3'h6);
  // one area at 16 bits is enough for a 16-bit bus
  assign next_bus16 = expanded && strap_done &&
                      !(&area_width_control);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_16bit      <= 1'b0;
      addr_space_16m <= 1'b0;
      port1_addr_en  <= 8'h00;
      port2_addr_en  <= 8'h00;
      port5_addr_en  <= 4'h0;
      porta_addr_en  <= 4'h0;
      port3_data_en  <= 1'b0;
      port4_data_en  <= 1'b0;
    end else if (!expanded || !strap_done) begin
      // single chip, or mode not yet known: all general I/O
      bus_16bit      <= 1'b0;
      addr_space_16m <= 1'b0;
      port1_addr_en  <= 8'h00;
      port2_addr_en  <= 8'h00;
      port5_addr_en  <= 4'h0;
      porta_addr_en  <= 4'h0;
      port3_data_en  <= 1'b0;
      port4_data_en  <= 1'b0;
    end else begin
      bus_16bit      <= next_bus16;
      addr_space_16m <= big_space;
      port3_data_en  <= 1'b1;
      port4_data_en  <= next_bus16;
      if (rom_modes) begin
        port1_addr_en <= port1_direction;
        port2_addr_en <= port2_direction;
        port5_addr_en <= port5_direction[3:0];
      end else begin
        port1_addr_en <= 8'hff;
        port2_addr_en <= 8'hff;
        port5_addr_en <= 4'hf;
      end
      if (big_space)
        porta_addr_en <= {~bus_release_control[7:5], 1'b1};
      else
        porta_addr_en <= 4'h0;
    end
  end
endmodule // scmp_top

// file: verification/scmp_ext_dev.sv
`timescale 1ns/1ns
// ==========================================================
// board side: straps, wake, nmi and hardware standby pins
module scmp_ext_dev (
  // clock
  input  wire logic  pclk,
  // pins toward the block
  output logic [2:0] mode_select_pins,
  output logic       nmi_pin,
  output logic       wake_irq_pin,
  output logic       hw_standby_n_pin
);
  // idle board levels before anything happens
  initial begin
    mode_select_pins = 3'h1;
    nmi_pin = 1'b1;
    wake_irq_pin = 1'b0;
    hw_standby_n_pin = 1'b1;
  end
  // straps move only while the chip is held in reset, never 000
  task automatic strap(input logic [2:0] m);
    @(posedge pclk) mode_select_pins <= m;
  endtask
  // wake is held past the two-stage synchroniser
  task automatic wake();
    @(posedge pclk) wake_irq_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    wake_irq_pin <= 1'b0;
  endtask
  // nmi level change, one edge per call
  task automatic nmi_level(input logic l);
    @(posedge pclk) nmi_pin <= l;
  endtask
  // low long enough to pass the synchroniser
  task automatic hw_standby();
    @(posedge pclk) hw_standby_n_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    hw_standby_n_pin <= 1'b1;
  endtask
endmodule // scmp_ext_dev

// file: verification/scmp_top_properties.sv
`timescale 1ns/1ns
// ==========================================================
// port-level properties of the system control block
module scmp_properties (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // power and control outputs
  input wire logic        halt_req,
  input wire logic        sleep_enter,
  input wire logic        soft_standby_enter,
  input wire logic        cpu_resume,
  input wire logic        secondary_mask_flag,
  input wire logic        onchip_ram_enable,
  // pin functions
  input wire logic [2:0]  mode_select_pins,
  input wire logic        addr_space_16m,
  input wire logic [7:4]  porta_addr_en,
  input wire logic [7:0]  port1_addr_en,
  input wire logic        port3_data_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase of a control write and of a control read
  sequence s_ctl_wr;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence
  sequence s_ctl_rd;
    psel && penable && pready && !pwrite && paddr == 8'h00;
  endsequence
  // ##2: the register takes the write at the access edge, the output one edge later
  chk_ram_follow: assert property (
    s_ctl_wr |-> ##2 onchip_ram_enable == $past(pwdata[0], 2))
    else $error("ram enable not following control bit 0");
  chk_mask_follow: assert property (
    s_ctl_wr |-> ##2 secondary_mask_flag == !$past(pwdata[3], 2))
    else $error("mask flag not inverse of control bit 3");
  chk_fixed_one: assert property (
    s_ctl_rd |-> prdata[1] && prdata[31:8] == 24'h0)
    else $error("control read lost bit 1 or upper zeros");
  chk_halt_cause: assert property (
    (sleep_enter || soft_standby_enter) |-> $past(halt_req))
    else $error("power entry without a halt request");
  chk_resume_pulse: assert property (
    cpu_resume |=> !cpu_resume)
    else $error("resume pulse longer than one cycle");
  chk_standby_wait: assert property (
    soft_standby_enter |=> !cpu_resume [*8])
    else $error("resume before the settling wait");
  chk_mode7_io: assert property (
    mode_select_pins == 3'h7 |->
      port1_addr_en == 8'h0 && porta_addr_en == 4'h0 && !port3_data_en)
    else $error("bus function in single-chip mode");
  chk_a20_space: assert property (
    porta_addr_en[4] == addr_space_16m)
    else $error("a20 not tied to the 16m space");
  chk_1m_space: assert property (
    mode_select_pins inside {3'h1, 3'h2, 3'h5, 3'h7} |-> !addr_space_16m)
    else $error("16m space in a 1m mode");
endmodule // scmp_properties

bind scmp_top scmp_properties i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .halt_req(halt_req), .sleep_enter(sleep_enter),
  .soft_standby_enter(soft_standby_enter), .cpu_resume(cpu_resume),
  .secondary_mask_flag(secondary_mask_flag),
  .onchip_ram_enable(onchip_ram_enable),
  .mode_select_pins(mode_select_pins), .addr_space_16m(addr_space_16m),
  .porta_addr_en(porta_addr_en), .port1_addr_en(port1_addr_en),
  .port3_data_en(port3_data_en));

// file: verification/tb.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench: apb reads and power events go via queues
module tb;
  // short waits keep the run small; real code picks >= 7 ms
  localparam int W[6] = '{16, 20, 24, 28, 32, 8};
  logic pclk = 0, presetn, psel, penable, pwrite;
  logic halt_req, hush = 0, s16, b16, ext, io;
  logic [7:0] paddr, v, d1, d2, d5;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sleep_enter, soft_standby_enter, cpu_resume;
  logic secondary_mask_flag, nmi_request, onchip_ram_enable, bus_16bit;
  logic addr_space_16m, port3_data_en, port4_data_en;
  logic [7:0] port1_addr_en, port2_addr_en;
  logic [3:0] port5_addr_en, ev;
  logic [7:4] porta_addr_en;
  wire logic [2:0] mode_select_pins;
  wire logic nmi_pin, wake_irq_pin, hw_standby_n_pin;
  logic [32:0] exp_q[$];
  logic [3:0] ev_q[$];
  int mismatches = 0, tests_run = 0, n;

  always #2 pclk = ~pclk;

  scmp_top #(.WAIT0(W[0]), .WAIT1(W[1]), .WAIT2(W[2]), .WAIT3(W[3]),
    .WAIT4(W[4]), .WAIT5(W[5])) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select_pins(mode_select_pins), .nmi_pin(nmi_pin),
    .wake_irq_pin(wake_irq_pin), .hw_standby_n_pin(hw_standby_n_pin),
    .halt_req(halt_req), .sleep_enter(sleep_enter),
    .soft_standby_enter(soft_standby_enter), .cpu_resume(cpu_resume),
    .secondary_mask_flag(secondary_mask_flag), .nmi_request(nmi_request),
    .onchip_ram_enable(onchip_ram_enable), .bus_16bit(bus_16bit),
    .addr_space_16m(addr_space_16m), .port1_addr_en(port1_addr_en),
    .port2_addr_en(port2_addr_en), .port5_addr_en(port5_addr_en),
    .porta_addr_en(porta_addr_en), .port3_data_en(port3_data_en),
    .port4_data_en(port4_data_en));

  scmp_ext_dev i_ext (.pclk(pclk), .mode_select_pins(mode_select_pins),
    .nmi_pin(nmi_pin), .wake_irq_pin(wake_irq_pin),
    .hw_standby_n_pin(hw_standby_n_pin));

  // ==========================================================
  // compare, report and end
  task automatic check(input string nm, input logic [32:0] e,
                       input logic [32:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // cuts a hang short, far beyond the several hundred cycles needed
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end

  // ==========================================================
  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    // wait states are the slave's; only the watchdog ends this wait
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge pclk);
  endtask
  task automatic halt();
    @(posedge pclk) halt_req <= 1'b1;
    @(posedge pclk) halt_req <= 1'b0;
  endtask
  task automatic do_reset(input logic [2:0] m);
    @(posedge pclk) presetn <= 1'b0;
    i_ext.strap(m);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wt(8);
  endtask
  // cycles from a wake request to the resume pulse
  task automatic wake_time(output int k);
    fork i_ext.wake(); join_none
    k = 0;
    do begin @(negedge pclk); k++; end
    while (cpu_resume !== 1'b1 && k < 400);
  endtask
  // every pin-function output against the decoded mode; bus_16bit only when io is set
  task automatic pins(input logic [7:0] p1, p2, p5, input logic b,
                      input logic [3:0] pa);
    wt(2);
    check("p1", ext ? 8'hff : (io ? p1 : 8'h0), port1_addr_en);
    check("p2", ext ? 8'hff : (io ? p2 : 8'h0), port2_addr_en);
    check("p5", ext ? 4'hf : (io ? p5[3:0] : 4'h0), port5_addr_en);
    check("pa", pa, porta_addr_en);
    check("m16", s16, addr_space_16m);
    check("p3", io, port3_data_en);
    check("p4", b, port4_data_en);
    if (io) check("b16", b, bus_16bit);
  endtask

  // each read or pulse takes the oldest note off its queue
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite)
      check("read", exp_q.size() ? exp_q.pop_front() : 33'h0,
            {pslverr, prdata});
    ev = {nmi_request & !hush, cpu_resume, soft_standby_enter, sleep_enter};
    if (ev !== 4'h0)
      check("event", 33'(ev_q.size() ? ev_q.pop_front() : 4'h0), 33'(ev));
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h915d));
    // bus idle and reset asserted before the first edge
    {presetn, psel, penable, pwrite, halt_req, paddr, pwdata} <= 45'h0;
    do_reset(3'h1);
    rd(8'h00, 33'h0b);
    rd(8'h04, 33'hff);
    rd(8'h08, 33'hff);
    rd(8'h1c, 33'h1_0000_0000);
    repeat (6) begin
      v = 8'($urandom());
      if (v[6]) v[5] = 1'b0; // stay off the illegal wait codes
      wr(8'h00, v);
      rd(8'h00, {25'h0, v | 8'h02});
      wt(1);
      check("ram_en", v[0], onchip_ram_enable);
      check("mask", !v[3], secondary_mask_flag);
    end
    // every mode, reset state then reconfigured bus
    for (int m = 1; m <= 7; m++) begin
      do_reset(3'(m));
      s16 = (m == 3 || m == 4 || m == 6);
      b16 = (m == 2 || m == 4);
      ext = (m < 5);
      io = (m < 7);
      pins(8'h0, 8'h0, 8'h0, b16 & io, s16 ? 4'h1 : 4'h0);
      d1 = 8'($urandom());
      d2 = 8'($urandom());
      d5 = 8'($urandom());
      wr(8'h08, 8'h1f);
      wr(8'h04, b16 ? 8'hff : 8'hf7);
      wr(8'h0c, d1);
      wr(8'h10, d2);
      wr(8'h14, d5);
      pins(d1, d2, d5, io & !b16, s16 ? 4'hf : 4'h0);
    end
    // sleep, a refused halt while asleep, quick resume
    ev_q.push_back(4'b0001);
    halt();
    halt();
    ev_q.push_back(4'b0100);
    wake_time(n);
    check("sleep_exit", 1'b1, n <= 8);
    // software standby with each wait code 0 to 5
    for (int c = 0; c < 6; c++) begin
      v = {1'b1, 3'(c), 4'b1010};
      wr(8'h00, v);
      ev_q.push_back(4'b0010);
      halt();
      wt(4);
      ev_q.push_back(4'b0100);
      wake_time(n);
      check("wait", 1'b1, n >= W[c] + 2 && n <= W[c] + 9);
      rd(8'h00, {25'h0, v});
    end
    // hardware standby reloads all but the ram enable
    i_ext.hw_standby();
    wt(6);
    rd(8'h00, 33'h0a);
    // falling edge selected, then rising
    ev_q.push_back(4'b1000);
    i_ext.nmi_level(1'b0);
    wt(6);
    i_ext.nmi_level(1'b1);
    wt(6);
    hush = 1'b1; // a select change may look like an edge
    wr(8'h00, 8'h0e);
    wt(6);
    hush = 1'b0;
    i_ext.nmi_level(1'b0);
    wt(6);
    ev_q.push_back(4'b1000);
    i_ext.nmi_level(1'b1);
    wt(8);
    check("pending", 33'h0, 33'(exp_q.size() + ev_q.size()));
    wrap_up();
  end
endmodule // tb
